// ===== irq_mux_pkg.sv
/*
 * package for the interrupt terminal multiplexer: register offsets,
 * field positions, reset values, frame timing and carrier types.
 * assumes a 32-bit axi4-lite register bus and one 10 MHz clock.
 */
package irq_mux_pkg;
   // byte addresses of the control and status words
   localparam logic [7:0] SYSTEM_CONTROL_OFS = 8'h80;
   localparam logic [7:0] DEVICE_CONTROL_OFS = 8'h84;
   localparam logic [7:0] CARD_CONTROL_OFS   = 8'h88;
   localparam logic [7:0] PIN_STATUS_OFS     = 8'h8C;
   // system control fields
   localparam int SYS_CLKRUN_EN_BIT  = 0;
   localparam int SYS_CLKRUN_SEL_BIT = 7;
   // device control fields
   localparam int DEV_PCI_INT_BIT    = 0;
   localparam int DEV_IRQ9_LSB       = 1;
   localparam int DEV_DMA_ALT_BIT    = 3;
   localparam logic [1:0] IRQ9_SERIAL = 2'h1;
   // card control fields
   localparam int CARD_RING_BIT      = 0;
   localparam int CARD_SUSPEND_BIT   = 1;
   // reset values: every terminal in plain interrupt request mode
   localparam logic [31:0] SYSTEM_CONTROL_RST = 32'h0000_0000;
   localparam logic [31:0] DEVICE_CONTROL_RST = 32'h0000_0000;
   localparam logic [31:0] CARD_CONTROL_RST   = 32'h0000_0000;
   // writable bits of each word, the rest read as zero
   localparam logic [31:0] SYSTEM_CONTROL_MASK = 32'h0000_0081;
   localparam logic [31:0] DEVICE_CONTROL_MASK = 32'h0000_000F;
   localparam logic [31:0] CARD_CONTROL_MASK   = 32'h0000_0003;
   // terminals that exist, by request number
   localparam logic [15:0] IRQ_PIN_MASK = 16'hDEB8;
   localparam int PIN_INTA = 3;
   localparam int PIN_INTB = 4;
   localparam int PIN_DMA_REQ = 7;
   localparam int PIN_SERIAL = 9;
   localparam int PIN_CLKRUN_A = 10;
   localparam int PIN_DMA_GNT = 11;
   localparam int PIN_CLKRUN_B = 12;
   localparam int PIN_RING = 15;
   // serial frame: one start slot then one slot per request
   localparam int SERIAL_SLOTS = 17;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [15:0] drv;
      logic [15:0] oe;
   } pin_drive_t;

   typedef struct packed {
      logic drv;
      logic oe;
   } one_pin_t;
endpackage : irq_mux_pkg

// ===== interrupt_pin_mux.sv
/*
 * interrupt terminal multiplexer with its axi4-lite register slave.
 * each terminal is output, output enable and input; the pad ring
 * resolves the wire. pin inputs are taken as synchronous to clk_i.
 */
`timescale 1ns/1ps
module interrupt_pin_mux (
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire logic [7:0]               s_axi_awaddr_i,
   input  wire logic                     s_axi_awvalid_i,
   output logic                          s_axi_awready_o,
   input  wire logic [31:0]              s_axi_wdata_i,
   input  wire logic [3:0]               s_axi_wstrb_i,
   input  wire logic                     s_axi_wvalid_i,
   output logic                          s_axi_wready_o,
   output logic [1:0]                    s_axi_bresp_o,
   output logic                          s_axi_bvalid_o,
   input  wire logic                     s_axi_bready_i,
   input  wire logic [7:0]               s_axi_araddr_i,
   input  wire logic                     s_axi_arvalid_i,
   output logic                          s_axi_arready_o,
   output logic [31:0]                   s_axi_rdata_o,
   output logic [1:0]                    s_axi_rresp_o,
   output logic                          s_axi_rvalid_o,
   input  wire logic                     s_axi_rready_i,
   input  wire logic [15:0]              irq_req_i,
   input  wire logic                     inta_i,
   input  wire logic                     intb_i,
   input  wire logic                     sideband_dma_request_i,
   output logic                          sideband_dma_grant_o,
   input  wire logic                     clkrun_drive_i,
   output logic                          clkrun_sense_o,
   input  wire logic                     card_ring_i,
   input  wire logic                     speaker_audio_i,
   output logic                          suspend_o,
   input  wire logic [15:0]              pins_i,
   output irq_mux_pkg::pin_drive_t       pins_o,
   input  wire logic                     spkr_pin_i,
   output irq_mux_pkg::one_pin_t         spkr_pin_o
);
   logic [31:0] system_control;
   logic [31:0] device_control;
   logic [31:0] card_control;
   logic        aw_got, w_got;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        aw_take, w_take, have_aw, have_w, do_wr;
   logic [7:0]  wr_addr;
   logic [31:0] wr_data, wr_merged, cur_word, rd_word;
   logic [3:0]  wr_strb;
   logic        next_aw_got, next_w_got, next_bvalid, next_rvalid;
   logic        rd_hit;
   logic [4:0]  slot;
   logic        serial_mode, pci_int, dma_alt, clkrun_en, clkrun_hi;
   logic        ring_en, susp_mode;
   irq_mux_pkg::pin_drive_t next_pins;
   irq_mux_pkg::one_pin_t   next_spkr;

   ////////////////////////////////////////////////////////////////////
   // axi4-lite write channel: address and data taken in either order
   assign aw_take = s_axi_awvalid_i & s_axi_awready_o;
   assign w_take  = s_axi_wvalid_i & s_axi_wready_o;
   assign have_aw = aw_got | aw_take;
   assign have_w  = w_got | w_take;
   assign do_wr   = have_aw & have_w;
   assign wr_addr = aw_got ? aw_addr : s_axi_awaddr_i;
   assign wr_data = w_got ? w_data : s_axi_wdata_i;
   assign wr_strb = w_got ? w_strb : s_axi_wstrb_i;
   assign next_aw_got = have_aw & ~do_wr;
   assign next_w_got  = have_w & ~do_wr;
   assign next_bvalid = do_wr | (s_axi_bvalid_o & ~s_axi_bready_i);

   // word currently held at the write address
   always_comb begin
      case (wr_addr)
         irq_mux_pkg::SYSTEM_CONTROL_OFS: cur_word = system_control;
         irq_mux_pkg::DEVICE_CONTROL_OFS: cur_word = device_control;
         irq_mux_pkg::CARD_CONTROL_OFS:   cur_word = card_control;
         default:                         cur_word = 32'h0000_0000;
      endcase
   end

   // byte lanes merged under the write strobes
   for (genvar b = 0; b < 4; b++) begin : g_lane
      assign wr_merged[8*b +: 8] = wr_strb[b] ? wr_data[8*b +: 8]
                                              : cur_word[8*b +: 8];
   end

   // channel handshakes; ready drops while a response is pending
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_got          <= 1'b0;
         w_got           <= 1'b0;
         aw_addr         <= 8'h00;
         w_data          <= 32'h0000_0000;
         w_strb          <= 4'h0;
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o  <= 1'b0;
         s_axi_bvalid_o  <= 1'b0;
         s_axi_bresp_o   <= irq_mux_pkg::RESP_OKAY;
      end else begin
         aw_got          <= next_aw_got;
         w_got           <= next_w_got;
         s_axi_awready_o <= ~next_aw_got & ~next_bvalid;
         s_axi_wready_o  <= ~next_w_got & ~next_bvalid;
         s_axi_bvalid_o  <= next_bvalid;
         if (aw_take) aw_addr <= s_axi_awaddr_i;
         if (w_take) begin
            w_data <= s_axi_wdata_i;
            w_strb <= s_axi_wstrb_i;
         end
         if (do_wr) begin
            s_axi_bresp_o <= (wr_addr == irq_mux_pkg::SYSTEM_CONTROL_OFS ||
                              wr_addr == irq_mux_pkg::DEVICE_CONTROL_OFS ||
                              wr_addr == irq_mux_pkg::CARD_CONTROL_OFS)
                             ? irq_mux_pkg::RESP_OKAY
                             : irq_mux_pkg::RESP_SLVERR;
         end
      end
   end

   // control words; zero after reset keeps plain request mode
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         system_control <= irq_mux_pkg::SYSTEM_CONTROL_RST;
         device_control <= irq_mux_pkg::DEVICE_CONTROL_RST;
         card_control   <= irq_mux_pkg::CARD_CONTROL_RST;
      end else if (do_wr) begin
         case (wr_addr)
            irq_mux_pkg::SYSTEM_CONTROL_OFS:
               system_control <= wr_merged & irq_mux_pkg::SYSTEM_CONTROL_MASK;
            irq_mux_pkg::DEVICE_CONTROL_OFS:
               device_control <= wr_merged & irq_mux_pkg::DEVICE_CONTROL_MASK;
            irq_mux_pkg::CARD_CONTROL_OFS:
               card_control   <= wr_merged & irq_mux_pkg::CARD_CONTROL_MASK;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // axi4-lite read channel, one cycle from address to data
   assign next_rvalid = (s_axi_arvalid_i & s_axi_arready_o)
                        | (s_axi_rvalid_o & ~s_axi_rready_i);

   always_comb begin
      rd_hit = 1'b1;
      case (s_axi_araddr_i)
         irq_mux_pkg::SYSTEM_CONTROL_OFS: rd_word = system_control;
         irq_mux_pkg::DEVICE_CONTROL_OFS: rd_word = device_control;
         irq_mux_pkg::CARD_CONTROL_OFS:   rd_word = card_control;
         irq_mux_pkg::PIN_STATUS_OFS:
            rd_word = {28'h000_0000, suspend_o,
                       pins_i[irq_mux_pkg::PIN_SERIAL],
                       clkrun_sense_o, sideband_dma_grant_o};
         default: begin
            rd_word = 32'h0000_0000;
            rd_hit  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= 32'h0000_0000;
         s_axi_rresp_o   <= irq_mux_pkg::RESP_OKAY;
      end else begin
         s_axi_arready_o <= ~next_rvalid;
         s_axi_rvalid_o  <= next_rvalid;
         if (s_axi_arvalid_i & s_axi_arready_o) begin
            s_axi_rdata_o <= rd_word;
            s_axi_rresp_o <= rd_hit ? irq_mux_pkg::RESP_OKAY
                                    : irq_mux_pkg::RESP_SLVERR;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // decoded mode bits
   assign serial_mode = device_control[irq_mux_pkg::DEV_IRQ9_LSB +: 2]
                        == irq_mux_pkg::IRQ9_SERIAL;
   assign pci_int   = device_control[irq_mux_pkg::DEV_PCI_INT_BIT];
   assign dma_alt   = device_control[irq_mux_pkg::DEV_DMA_ALT_BIT];
   assign clkrun_en = system_control[irq_mux_pkg::SYS_CLKRUN_EN_BIT];
   assign clkrun_hi = system_control[irq_mux_pkg::SYS_CLKRUN_SEL_BIT];
   assign ring_en   = card_control[irq_mux_pkg::CARD_RING_BIT];
   assign susp_mode = card_control[irq_mux_pkg::CARD_SUSPEND_BIT];

   // serial frame slot counter, free running so a frame is always due
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) slot <= 5'h00;
      else if (slot == 5'(irq_mux_pkg::SERIAL_SLOTS - 1)) slot <= 5'h00;
      else slot <= slot + 5'h01;
   end

   // terminal mux: plain request first, alternates override it
   always_comb begin
      for (int n = 0; n < 16; n++) begin
         next_pins.drv[n] = irq_req_i[n] & irq_mux_pkg::IRQ_PIN_MASK[n];
         next_pins.oe[n]  = ~serial_mode & irq_mux_pkg::IRQ_PIN_MASK[n];
      end
      if (pci_int) begin
         next_pins.drv[irq_mux_pkg::PIN_INTA] = 1'b0;
         next_pins.oe[irq_mux_pkg::PIN_INTA]  = inta_i;
         next_pins.drv[irq_mux_pkg::PIN_INTB] = 1'b0;
         next_pins.oe[irq_mux_pkg::PIN_INTB]  = intb_i;
      end
      if (dma_alt) begin
         next_pins.drv[irq_mux_pkg::PIN_DMA_REQ] =
            sideband_dma_request_i;
         next_pins.oe[irq_mux_pkg::PIN_DMA_REQ]  = 1'b1;
         next_pins.drv[irq_mux_pkg::PIN_DMA_GNT] = 1'b0;
         next_pins.oe[irq_mux_pkg::PIN_DMA_GNT]  = 1'b0;
      end
      if (serial_mode) begin
         // open drain: pulled low for the start slot and each request
         next_pins.drv[irq_mux_pkg::PIN_SERIAL] = 1'b0;
         next_pins.oe[irq_mux_pkg::PIN_SERIAL]  = (slot == 5'h00) ||
                                                  irq_req_i[4'(slot - 5'h01)];
      end
      if (clkrun_en) begin
         if (clkrun_hi) begin
            next_pins.drv[irq_mux_pkg::PIN_CLKRUN_B] = 1'b0;
            next_pins.oe[irq_mux_pkg::PIN_CLKRUN_B]  = clkrun_drive_i;
         end else begin
            next_pins.drv[irq_mux_pkg::PIN_CLKRUN_A] = 1'b0;
            next_pins.oe[irq_mux_pkg::PIN_CLKRUN_A]  = clkrun_drive_i;
         end
      end
      if (ring_en) begin
         next_pins.drv[irq_mux_pkg::PIN_RING] = card_ring_i;
         next_pins.oe[irq_mux_pkg::PIN_RING]  = 1'b1;
      end
      next_spkr.drv = susp_mode ? 1'b0 : speaker_audio_i;
      next_spkr.oe  = ~susp_mode;
   end

   // registered pins and sampled inputs, one cycle behind the mux
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pins_o               <= '0;
         spkr_pin_o           <= '0;
         sideband_dma_grant_o <= 1'b0;
         clkrun_sense_o       <= 1'b0;
         suspend_o            <= 1'b0;
      end else begin
         pins_o               <= next_pins;
         spkr_pin_o           <= next_spkr;
         sideband_dma_grant_o <= dma_alt & pins_i[irq_mux_pkg::PIN_DMA_GNT];
         clkrun_sense_o       <= clkrun_hi ? pins_i[irq_mux_pkg::PIN_CLKRUN_B]
                                           : pins_i[irq_mux_pkg::PIN_CLKRUN_A];
         suspend_o            <= susp_mode & spkr_pin_i;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks on the terminal mux
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_inta_select: assert property (pci_int && !serial_mode |=>
      !pins_o.drv[3] && pins_o.oe[3] == $past(inta_i))
      else $error("inta terminal wrong");
   a_dma_request: assert property (dma_alt |=>
      pins_o.oe[7] && pins_o.drv[7] == $past(sideband_dma_request_i))
      else $error("dma request terminal wrong");
   a_dma_grant_in: assert property (dma_alt |=>
      !pins_o.oe[11] && sideband_dma_grant_o == $past(pins_i[11]))
      else $error("dma grant not passed");
   a_irq9_field: assert property (
      device_control[2:1] == 2'h1 && slot == 5'h00 |=>
      pins_o.oe[9] && !pins_o.drv[9])
      else $error("serial start slot missing");
   a_serial_frame: assert property (serial_mode && slot == 5'h05
      && !pci_int && irq_req_i[4] |=> pins_o.oe[9] && !pins_o.oe[4])
      else $error("serial slot not driven");
   a_clkrun_low: assert property (clkrun_en && !clkrun_hi |=>
      !pins_o.drv[10] && pins_o.oe[10] == $past(clkrun_drive_i))
      else $error("clockrun on irq10 wrong");
   a_clkrun_sel: assert property (clkrun_en && clkrun_hi |=>
      !pins_o.drv[12] && pins_o.oe[12] == $past(clkrun_drive_i))
      else $error("clockrun on irq12 wrong");
   a_isa_serial: assert property (serial_mode |=>
      !pins_o.oe[5] && !pins_o.oe[14])
      else $error("parallel request driven in serial mode");
   a_ring_out: assert property (ring_en |=>
      pins_o.oe[15] && pins_o.drv[15] == $past(card_ring_i))
      else $error("ring indicate not passed");
   // pins still show reset values one edge after release
   a_speaker_out: assert property (
      !susp_mode && !$past(rst_i) |=>
      spkr_pin_o.oe && spkr_pin_o.drv == $past(speaker_audio_i) && !suspend_o)
      else $error("speaker terminal wrong");
   a_isa_default: assert property (device_control == 32'h0 &&
      system_control == 32'h0 && card_control == 32'h0 && !$past(rst_i) |=>
      pins_o.oe[9] && pins_o.drv[9] == $past(irq_req_i[9]))
      else $error("plain request mode wrong");

   c_serial_mode: cover property (serial_mode && slot == 5'h10);
   c_clkrun_b:    cover property (clkrun_en && clkrun_hi && clkrun_drive_i);
   c_suspend:     cover property (susp_mode ##1 suspend_o);
   c_write_resp:  cover property (s_axi_bvalid_o && s_axi_bready_i);
endmodule : interrupt_pin_mux

// ===== irq_far_side.sv
/*
 * far-side model: system interrupt controller and chipset dma logic.
 * assumes board pull-ups on every terminal but irq11 and the speaker line, and an active-high grant.
 */
`timescale 1ns/1ps
module irq_far_side (
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire irq_mux_pkg::pin_drive_t  pins_o,
   input  wire irq_mux_pkg::one_pin_t    spkr_pin_o,
   input  wire logic [3:0]               grant_delay_i,
   input  wire logic                     suspend_req_i,
   output logic [15:0]                   pin_level_o,
   output logic                          spkr_level_o
);
   logic [3:0] wait_cnt;
   logic       grant;
   logic       dma_req;

   ////////////////////////////////////////////////////////////////////
   // grant only while request stands, after a chosen delay
   assign dma_req = pin_level_o[7] && !pins_o.oe[11];
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wait_cnt <= 4'h0;
         grant    <= 1'b0;
      end else if (!dma_req) begin
         wait_cnt <= 4'h0;
         grant    <= 1'b0;
      end else if (wait_cnt == grant_delay_i) begin
         grant <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // released lines float high except irq11 (grant) and the speaker line (suspend_req_i), never hold a stale value
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         pin_level_o[i] = pins_o.oe[i] ? pins_o.drv[i] : 1'b1;
      end
      if (!pins_o.oe[11]) begin
         pin_level_o[11] = grant;
      end
   end
   assign spkr_level_o = spkr_pin_o.oe ? spkr_pin_o.drv : suspend_req_i;
endmodule : irq_far_side

// ===== testbench.sv
/*
 * self-checking bench for the interrupt terminal multiplexer.
 * assumes the far-side model in irq_far_side and a 10 MHz clock.
 */
`timescale 1ns/1ps
module testbench;
   logic        clk_i, rst_i, inta_i, intb_i, card_ring_i;
   logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
   logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
   logic [3:0]  s_axi_wstrb_i, grant_delay;
   logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i;
   logic        s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
   logic        s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o;
   logic        s_axi_rready_i, sideband_dma_request_i;
   logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
   logic [15:0] irq_req_i, pins_i;
   logic        sideband_dma_grant_o, clkrun_drive_i, clkrun_sense_o;
   logic        speaker_audio_i, suspend_o, spkr_pin_i, suspend_req;
   irq_mux_pkg::pin_drive_t pins_o;
   irq_mux_pkg::one_pin_t   spkr_pin_o;
   int          fails, comparisons;

   interrupt_pin_mux interrupt_pin_mux_inst (
      .clk_i(clk_i), .rst_i(rst_i),
      .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
      .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
      .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
      .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
      .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
      .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
      .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
      .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
      .s_axi_rready_i(s_axi_rready_i), .irq_req_i(irq_req_i),
      .inta_i(inta_i), .intb_i(intb_i),
      .sideband_dma_request_i(sideband_dma_request_i),
      .sideband_dma_grant_o(sideband_dma_grant_o),
      .clkrun_drive_i(clkrun_drive_i), .clkrun_sense_o(clkrun_sense_o),
      .card_ring_i(card_ring_i), .speaker_audio_i(speaker_audio_i),
      .suspend_o(suspend_o), .pins_i(pins_i), .pins_o(pins_o),
      .spkr_pin_i(spkr_pin_i), .spkr_pin_o(spkr_pin_o));
   irq_far_side irq_far_side_inst (
      .clk_i(clk_i), .rst_i(rst_i), .pins_o(pins_o),
      .spkr_pin_o(spkr_pin_o), .grant_delay_i(grant_delay),
      .suspend_req_i(suspend_req), .pin_level_o(pins_i),
      .spkr_level_o(spkr_pin_i));

   ////////////////////////////////////////////////////////////////////
   // shared helpers
   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic settle;
      // registered sampling of far-side levels needs a fourth edge
      repeat (4) @(posedge clk_i);
   endtask : settle
   task automatic conclude;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude
   // bus master: hold each channel until taken, bounded waits
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d,
                            input logic [1:0] er);
      int n;
      @(posedge clk_i);
      s_axi_awaddr_i <= a;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wdata_i <= d;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_i);
         if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
         if (s_axi_bvalid_o) begin
            s_axi_bready_i <= 1'b0;
            check("bresp", {30'h0, er}, {30'h0, s_axi_bresp_o});
            break;
         end
      end
      if (n == 40) begin
         fails++;
         conclude;
      end
   endtask : reg_write
   task automatic reg_read(input logic [7:0] a, input logic [31:0] ed,
                           input logic [1:0] er);
      int n;
      @(posedge clk_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_i);
         if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
         if (s_axi_rvalid_o) begin
            s_axi_rready_i <= 1'b0;
            check("rdata", ed, s_axi_rdata_o);
            check("rresp", {30'h0, er}, {30'h0, s_axi_rresp_o});
            break;
         end
      end
      if (n == 40) begin
         fails++;
         conclude;
      end
   endtask : reg_read

   ////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic test_reset_state;
      reg_read(8'h80, 32'h0, 2'h0);
      reg_read(8'h84, 32'h0, 2'h0);
      reg_read(8'h88, 32'h0, 2'h0);
      reg_read(8'h90, 32'h0, 2'h2);
      reg_write(8'h8C, 32'hF, 2'h2);
      reg_write(8'h80, 32'hFFFF_FFFF, 2'h0);
      reg_read(8'h80, 32'h81, 2'h0);
      reg_write(8'h80, 32'h0, 2'h0);
      irq_req_i <= 16'h4120;
      settle;
      check("oe", 32'hDEB8, {16'h0, pins_o.oe});
      check("drv", 32'h4020, {16'h0, pins_o.drv});
      $display("test reset_state done");
   endtask : test_reset_state
   task automatic test_pci_int;
      reg_write(8'h84, 32'h1, 2'h0);
      irq_req_i <= 16'h0018;
      inta_i <= 1'b1;
      settle;
      check("int pins", 32'h2, {30'h0, pins_i[4:3]});
      inta_i <= 1'b0;
      intb_i <= 1'b1;
      settle;
      check("int pins", 32'h1, {30'h0, pins_i[4:3]});
      reg_write(8'h84, 32'h0, 2'h0);
      irq_req_i <= 16'h0010;
      settle;
      check("irq pins", 32'h2, {30'h0, pins_i[4:3]});
      intb_i <= 1'b0;
      $display("test pci_int done");
   endtask : test_pci_int
   task automatic test_dma(input logic [3:0] dly);
      int n;
      reg_write(8'h84, 32'h8, 2'h0);
      grant_delay <= dly;
      settle;
      check("req pin idle", 32'h0, {31'h0, pins_i[7]});
      check("gnt oe", 32'h0, {31'h0, pins_o.oe[11]});
      sideband_dma_request_i <= 1'b1;
      settle;
      check("req pin", 32'h1, {31'h0, pins_i[7]});
      for (n = 0; n < 20 && sideband_dma_grant_o !== 1'b1; n++)
         @(posedge clk_i);
      check("grant", 32'h1, {31'h0, sideband_dma_grant_o});
      if (n == 20) conclude;
      reg_read(8'h8C, 32'h1, 2'h0);
      sideband_dma_request_i <= 1'b0;
      settle;
      check("grant off", 32'h0, {31'h0, sideband_dma_grant_o});
      reg_write(8'h84, 32'h0, 2'h0);
      $display("test dma done");
   endtask : test_dma
   task automatic test_serial;
      int cnt;
      irq_req_i <= 16'h0215;
      reg_write(8'h84, 32'h4, 2'h0);
      settle;
      check("irq9 parallel", 32'h1, {31'h0, pins_i[9]});
      reg_write(8'h84, 32'h2, 2'h0);
      settle;
      cnt = 0;
      repeat (17) begin
         @(posedge clk_i);
         cnt += pins_o.oe[9];
      end
      check("serial slots", 32'h5, cnt);
      check("irq5 oe", 32'h0, {31'h0, pins_o.oe[5]});
      reg_write(8'h84, 32'h0, 2'h0);
      $display("test serial done");
   endtask : test_serial
   task automatic test_clkrun;
      irq_req_i <= 16'h1400;
      reg_write(8'h80, 32'h1, 2'h0);
      clkrun_drive_i <= 1'b1;
      settle;
      check("pin10", 32'h0, {31'h0, pins_i[10]});
      check("sense", 32'h0, {31'h0, clkrun_sense_o});
      clkrun_drive_i <= 1'b0;
      settle;
      check("pin10 oe", 32'h0, {31'h0, pins_o.oe[10]});
      check("sense", 32'h1, {31'h0, clkrun_sense_o});
      reg_write(8'h80, 32'h81, 2'h0);
      clkrun_drive_i <= 1'b1;
      settle;
      check("pin12", 32'h0, {31'h0, pins_i[12]});
      check("pin10", 32'h1, {31'h0, pins_o.drv[10]});
      clkrun_drive_i <= 1'b0;
      reg_write(8'h80, 32'h0, 2'h0);
      $display("test clkrun done");
   endtask : test_clkrun
   task automatic test_card;
      irq_req_i <= 16'h0000;
      reg_write(8'h88, 32'h1, 2'h0);
      card_ring_i <= 1'b1;
      settle;
      check("ring", 32'h1, {31'h0, pins_i[15]});
      reg_write(8'h88, 32'h0, 2'h0);
      speaker_audio_i <= 1'b1;
      settle;
      check("ring off", 32'h0, {31'h0, pins_i[15]});
      check("speaker", 32'h3, {30'h0, spkr_pin_o});
      reg_write(8'h88, 32'h2, 2'h0);
      suspend_req <= 1'b1;
      settle;
      check("spkr oe", 32'h0, {31'h0, spkr_pin_o.oe});
      check("suspend", 32'h1, {31'h0, suspend_o});
      suspend_req <= 1'b0;
      settle;
      check("suspend off", 32'h0, {31'h0, suspend_o});
      $display("test card done");
   endtask : test_card

   ////////////////////////////////////////////////////////////////////
   // clock, reset and the run order
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   initial begin
      {rst_i, s_axi_wstrb_i} = 5'h1F;
      {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 48'h0;
      {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 3'h0;
      {s_axi_arvalid_i, s_axi_rready_i, inta_i, intb_i} = 4'h0;
      {irq_req_i, sideband_dma_request_i, clkrun_drive_i} = 18'h0;
      {card_ring_i, speaker_audio_i, suspend_req} = 3'h0;
      grant_delay = 4'h0;
      fails = 0;
      comparisons = 0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      test_reset_state;
      test_pci_int;
      test_dma(4'h0);
      test_dma(4'h6);
      test_serial;
      test_clkrun;
      test_card;
      conclude;
   end
endmodule : testbench
